// ==== rtl/rts_pkg.sv ====
// Shared constants and carriers for the radio test signal sequencer.
// Assumes a single symbol-rate clock; all users import rts_pkg::*.
package rts_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] RTS_REG_CTRL = 8'h00;
  localparam logic [7:0] RTS_REG_ECC = 8'h04;
  localparam logic [7:0] RTS_REG_FREQ = 8'h08;
  localparam logic [7:0] RTS_REG_DUPLEX = 8'h0C;
  localparam logic [7:0] RTS_REG_STATUS = 8'h10;
  localparam logic [7:0] RTS_REG_RAND = 8'h14;
  // ==========================================================
  // Field positions
  localparam int RTS_CTRL_EN_BIT = 0;
  localparam int RTS_CTRL_BS_BIT = 1;
  localparam int RTS_CTRL_INTF_BIT = 2;
  localparam int RTS_CTRL_TYPE_LSB = 4;
  // ==========================================================
  // Reset values and structure
  localparam logic [3:0] RTS_TYPE_RST = 4'h1;
  localparam logic [29:0] RTS_ECC_RST = 30'h00000000;
  localparam logic [31:0] RTS_FREQ_RST = 32'h00000000;
  localparam logic [7:0] RTS_DUPLEX_RST = 8'h00;
  localparam logic [8:0] RTS_PRBS_SEED = 9'h1FF;
  localparam logic [31:0] RTS_SCR_SEED_LOW = 32'h00000003;
  localparam logic [31:0] RTS_LFSR_RST = 32'h00000001;
  localparam int RTS_SLOT_SYMS = 255;
  localparam int RTS_SLOTS = 4;
  localparam int RTS_FRAMES = 18;
  localparam int RTS_CTRL_FRAME = 18;
  localparam int RTS_FILT_SPAN = 15;
  localparam int RTS_SYNC_SYMS = 255;
  localparam int RTS_GAP_MIN_SYM = 800;
  localparam int RTS_GAP_MAX_SYM = 25000;
  localparam int RTS_SUBSYM = 4;
  localparam int RTS_GAP_MIN_Q = RTS_GAP_MIN_SYM * RTS_SUBSYM;
  localparam int RTS_GAP_SPAN_Q = (RTS_GAP_MAX_SYM - RTS_GAP_MIN_SYM) * RTS_SUBSYM;
  localparam int RTS_FIFO_DEPTH = 16;
  // ==========================================================
  // Channel types
  localparam logic [3:0] RTS_CT_FILL_MS = 4'd0;
  localparam logic [3:0] RTS_CT_SYNC_MS = 4'd3;
  localparam logic [3:0] RTS_CT_FILL_BS = 4'd7;
  localparam logic [3:0] RTS_CT_SCHF_BS = 4'd8;
  localparam logic [3:0] RTS_CT_RAND = 4'd13;
  // ==========================================================
  // Burst kind and block content
  typedef enum logic [1:0] {RTS_BURST_NORMAL, RTS_BURST_SYNC, RTS_BURST_CONTROL, RTS_BURST_OFF}
    rts_burst_t;
  typedef enum logic [2:0] {RTS_SRC_PRBS, RTS_SRC_SYNCINFO, RTS_SRC_TESTBCAST, RTS_SRC_ACCESS,
    RTS_SRC_ANY} rts_src_t;
  typedef struct packed {
    logic [1:0] slot;
    logic [4:0] frame;
    logic [3:0] chan_type;
    rts_burst_t burst;
    logic on_air;
  } rts_slot_info_t;
  typedef struct packed {
    logic bit_val;
    logic modulate;
    logic [1:0] slot;
    logic [4:0] frame;
    logic [3:0] chan_type;
  } rts_sym_t;
  localparam int RTS_SYM_W = $bits(rts_sym_t);
endpackage

// ==== rtl/rts_sequencer.sv ====
// Radio test signal sequencer: multiframe timing, content choice, scrambling, payload.
// Assumes one symbol clock, synchronous inputs and a plain register port.
// Notes on behaviour
// - Filter span at least fifteen, parabolic window
// - Frames one to seventeen payload, eighteen control
// - Mobile frame eighteen slot one: sync burst
// - Broadcast carries downlink frequency and duplex fields
// - Mobile frames one to seventeen: selected type
// - Scramble with thirty-bit colour code; sync zero
// - Payload from repeating 511-bit pseudo-random generator
// - Channels not under test may carry anything
// - Mobile types one-four: filler zero slots two-four
// - Type thirteen: random sync bursts, 800-25000 spacing
// - Silent between random sync bursts
// - Base frame eighteen slot one: type eight
// - Base frames one to seventeen: selected type
// - Base filler type seven slots two-four
// - Interferer bits all straight from generator
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

// ==========================================================
// Synchronous FIFO
module rts_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,  // Clock
  input wire logic resetn,  // Async reset, low
  input wire logic in_valid,  // Write request
  output logic in_ready,  // Space available
  input wire logic [WIDTH-1:0] in_data,  // Write word
  output logic out_valid,  // Word available
  input wire logic out_ready,  // Consumer takes word
  output logic [WIDTH-1:0] out_data  // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = cnt_q != DEPTH[AW:0];
  assign out_valid = cnt_q != '0;
  assign out_data = mem[rd_q];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ==========================================================
// Sequencer top
module rts_sequencer (
  input wire logic clk,  // Symbol clock, 40 MHz
  input wire logic resetn,  // Async reset, low
  input wire logic [7:0] reg_addr,  // Register byte address
  input wire logic [31:0] reg_wdata,  // Write data
  input wire logic reg_wr,  // Write strobe
  input wire logic reg_rd,  // Read strobe
  output logic [31:0] reg_rdata,  // Read data, cycle after strobe
  input wire logic sym_ready,  // Modulator takes a symbol bit
  output logic sym_valid,  // Symbol bit valid
  output logic sym_bit,  // Scrambled bit to modulator
  output logic sym_on_air,  // Transmitter keyed
  output logic [1:0] sym_slot,  // Slot number minus one
  output logic [4:0] sym_frame,  // Frame number 1..18
  output logic [3:0] sym_chan_type  // Channel type in force
);
  import rts_pkg::*;

  // ========================================================
  // Registers
  logic enable_q;
  logic bs_mode_q;
  logic intf_mode_q;
  logic [3:0] sel_type_q;
  logic [29:0] colour_q;
  logic [31:0] freq_q;
  logic [7:0] duplex_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] slot_q;
  logic [4:0] frame_q;
  logic [7:0] sym_q;
  logic [8:0] prbs_q;
  logic [31:0] scr_q;
  logic [31:0] lfsr_q;
  logic [16:0] gap_q;
  logic [1:0] sub_q;
  logic [RTS_SYM_W-1:0] out_q;
  logic out_valid_q;
  logic on_air_q;

  // Window weight numerator for tap j: (N+1)^2/4 - (j-(N-1)/2)^2, scaled by 4
  function automatic logic [15:0] rts_window(input int j);
    int n;
    int d;
    n = RTS_FILT_SPAN;
    d = 2 * j - (n - 1);
    return 16'((n + 1) * (n + 1) - d * d);
  endfunction

  // Filter span and window table; the centre tap is read back in the STATUS register
  localparam int RTS_TAPS = RTS_FILT_SPAN;
  logic [15:0] win_tab [RTS_TAPS];
  for (genvar gj = 0; gj < RTS_TAPS; gj++) begin : g_win
    assign win_tab[gj] = rts_window(gj);
  end

  wire ctrl_hit = reg_addr == RTS_REG_CTRL;
  wire ecc_hit = reg_addr == RTS_REG_ECC;
  wire freq_hit = reg_addr == RTS_REG_FREQ;
  wire dup_hit = reg_addr == RTS_REG_DUPLEX;
  wire stat_hit = reg_addr == RTS_REG_STATUS;
  wire rand_hit = reg_addr == RTS_REG_RAND;

  always_comb begin
    rdata_d = 32'h00000000;
    if (ctrl_hit) begin
      rdata_d = {24'h000000, sel_type_q, 1'b0, intf_mode_q, bs_mode_q, enable_q};
    end else if (ecc_hit) begin
      rdata_d = {2'b00, colour_q};
    end else if (freq_hit) begin
      rdata_d = freq_q;
    end else if (dup_hit) begin
      rdata_d = {24'h000000, duplex_q};
    end else if (stat_hit) begin
      rdata_d = {win_tab[RTS_TAPS/2], 3'b000, frame_q, 6'h00, slot_q};
    end else if (rand_hit) begin
      rdata_d = {13'h0000, sub_q, gap_q};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enable_q <= 1'b0;
      bs_mode_q <= 1'b0;
      intf_mode_q <= 1'b0;
      sel_type_q <= RTS_TYPE_RST;
      colour_q <= RTS_ECC_RST;
      freq_q <= RTS_FREQ_RST;
      duplex_q <= RTS_DUPLEX_RST;
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= reg_rd ? rdata_d : 32'h00000000;
      if (reg_wr && ctrl_hit) begin
        enable_q <= reg_wdata[RTS_CTRL_EN_BIT];
        bs_mode_q <= reg_wdata[RTS_CTRL_BS_BIT];
        intf_mode_q <= reg_wdata[RTS_CTRL_INTF_BIT];
        sel_type_q <= reg_wdata[RTS_CTRL_TYPE_LSB +: 4];
      end
      if (reg_wr && ecc_hit) colour_q <= reg_wdata[29:0];
      if (reg_wr && freq_hit) freq_q <= reg_wdata;
      if (reg_wr && dup_hit) duplex_q <= reg_wdata[7:0];
    end
  end
  assign reg_rdata = rdata_q;

  // ========================================================
  // Slot content selection
  wire fifo_ready;
  wire random_mode = !bs_mode_q && sel_type_q == RTS_CT_RAND;
  wire ctrl_frame = frame_q == 5'(RTS_CTRL_FRAME);
  wire first_slot = slot_q == 2'd0;
  wire in_burst = sym_q < 8'(RTS_SYNC_SYMS);
  logic [3:0] cur_type;
  rts_burst_t cur_burst;
  rts_src_t cur_src;
  wire [3:0] filler_type = bs_mode_q ? RTS_CT_FILL_BS : RTS_CT_FILL_MS;
  wire [3:0] frame18_type = bs_mode_q ? RTS_CT_SCHF_BS : RTS_CT_SYNC_MS;

  always_comb begin
    cur_type = sel_type_q;
    cur_burst = RTS_BURST_NORMAL;
    cur_src = RTS_SRC_PRBS;
    if (intf_mode_q) begin
      cur_src = RTS_SRC_PRBS;
    end else if (random_mode) begin
      cur_type = RTS_CT_RAND;
      cur_burst = gap_q == '0 && in_burst ? RTS_BURST_SYNC : RTS_BURST_OFF;
      cur_src = RTS_SRC_SYNCINFO;
    end else if (!first_slot) begin
      cur_type = filler_type;
      cur_src = RTS_SRC_ANY;
    end else if (ctrl_frame) begin
      cur_type = frame18_type;
      cur_burst = bs_mode_q ? RTS_BURST_NORMAL : RTS_BURST_SYNC;
      cur_src = bs_mode_q ? RTS_SRC_PRBS : (sym_q[7] ? RTS_SRC_TESTBCAST : RTS_SRC_SYNCINFO);
    end else begin
      cur_type = sel_type_q;
      if (sel_type_q == RTS_CT_SYNC_MS && !bs_mode_q) cur_burst = RTS_BURST_SYNC;
      if (sel_type_q == 4'd11) cur_burst = RTS_BURST_CONTROL;
    end
  end

  // Burst bits: access channel in the last few symbols, else block content
  wire access_pos = sym_q[7:3] == 5'h1F;
  logic info_bit;
  always_comb begin
    info_bit = prbs_q[0];
    if (!intf_mode_q && access_pos) begin
      info_bit = ^{slot_q, frame_q};
    end else if (cur_src == RTS_SRC_SYNCINFO) begin
      info_bit = colour_q[5'(sym_q % 30)];
    end else if (cur_src == RTS_SRC_TESTBCAST) begin
      info_bit = sym_q[6] ? duplex_q[sym_q[2:0]] : freq_q[sym_q[4:0]];
    end else if (cur_src == RTS_SRC_ANY) begin
      info_bit = 1'b0;
    end
  end
  wire sync_block = cur_src == RTS_SRC_SYNCINFO;
  wire scr_bit = sync_block || intf_mode_q ? 1'b0 : scr_q[0];
  wire on_air = enable_q && cur_burst != RTS_BURST_OFF;
  wire advance = enable_q && fifo_ready;
  wire take_prbs = advance && (intf_mode_q || cur_src == RTS_SRC_PRBS);
  wire slot_end = sym_q == 8'(RTS_SLOT_SYMS - 1);
  wire frame_end = slot_end && slot_q == 2'(RTS_SLOTS - 1);
  rts_sym_t sym_d;
  assign sym_d = '{bit_val: (on_air ? info_bit ^ scr_bit : 1'b0), modulate: on_air,
    slot: slot_q, frame: frame_q, chan_type: cur_type};

  // ========================================================
  // Timing and generators
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slot_q <= 2'd0;
      frame_q <= 5'd1;
      sym_q <= 8'h00;
      prbs_q <= RTS_PRBS_SEED;
      scr_q <= RTS_SCR_SEED_LOW;
      lfsr_q <= RTS_LFSR_RST;
      gap_q <= 17'h00000;
      sub_q <= 2'd0;
    end else if (advance) begin
      lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      if (take_prbs) begin
        prbs_q <= {prbs_q[4] ^ prbs_q[0], prbs_q[8:1]};
      end
      scr_q <= {scr_q[0] ^ scr_q[6] ^ scr_q[9] ^ scr_q[10] ^ scr_q[16] ^ scr_q[20] ^
        scr_q[21] ^ scr_q[22] ^ scr_q[24] ^ scr_q[25] ^ scr_q[27] ^ scr_q[28] ^
        scr_q[30] ^ scr_q[31], scr_q[31:1]};
      if (random_mode) begin
        // Quarter-symbol steps between burst starts, counted down in symbols
        if (gap_q == '0 && slot_end) begin
          gap_q <= 17'((RTS_GAP_MIN_Q + int'(lfsr_q[16:0]) % RTS_GAP_SPAN_Q) / RTS_SUBSYM
            - RTS_SLOT_SYMS);
          sub_q <= lfsr_q[18:17];
          sym_q <= 8'h00;
        end else if (gap_q != '0) begin
          gap_q <= gap_q - 1'b1;
        end else begin
          sym_q <= sym_q + 1'b1;
        end
      end else begin
        sym_q <= slot_end ? 8'h00 : sym_q + 1'b1;
        if (slot_end) begin
          slot_q <= slot_q + 1'b1;
          scr_q <= {colour_q, 2'b11};
        end
        if (frame_end) begin
          frame_q <= frame_q == 5'(RTS_FRAMES) ? 5'd1 : frame_q + 1'b1;
        end
      end
    end
  end

  // ========================================================
  // Output buffer toward the modulator
  wire fifo_out_valid;
  wire [RTS_SYM_W-1:0] fifo_out_data;
  rts_sym_t fifo_word;
  assign fifo_word = fifo_out_data;
  rts_fifo #(.WIDTH(RTS_SYM_W), .DEPTH(RTS_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(enable_q),
    .in_ready(fifo_ready),
    .in_data(sym_d),
    .out_valid(fifo_out_valid),
    .out_ready(sym_ready || !out_valid_q),
    .out_data(fifo_out_data)
  );
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_q <= '0;
      out_valid_q <= 1'b0;
      on_air_q <= 1'b0;
    end else if (sym_ready || !out_valid_q) begin
      out_valid_q <= fifo_out_valid;
      on_air_q <= fifo_out_valid && fifo_word.modulate;
      if (fifo_out_valid) out_q <= fifo_out_data;
    end
  end
  rts_sym_t out_s;
  assign out_s = out_q;
  assign sym_valid = out_valid_q;
  assign sym_bit = out_s.bit_val;
  assign sym_on_air = on_air_q;
  assign sym_slot = out_s.slot;
  assign sym_frame = out_s.frame;
  assign sym_chan_type = out_s.chan_type;
endmodule

// ==== sim/rts_rx_model.sv ====
// Receiver under test at the sequencer's symbol output.
// Assumes the sequencer's clock; slow holds off 16 of every 64 cycles.
`timescale 1ns/1ps
module rts_rx_model (
  input wire logic clk,  // Clock
  input wire logic resetn,  // Reset, low
  input wire logic slow,  // Stall bursts on
  input wire logic sym_valid,  // Symbol present
  input wire logic sym_bit,  // Scrambled bit
  input wire logic sym_on_air,  // Keyed
  output logic sym_ready,  // Symbol taken
  output logic [31:0] rx_bits  // Keyed bits taken
);
  logic [5:0] ph_q;
  logic last_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ph_q <= 6'h0;
      sym_ready <= 1'b0;
      rx_bits <= 32'h0;
      last_q <= 1'b0;
    end else begin
      ph_q <= ph_q + 6'h1;
      // Long stalls let the sequencer's buffer fill up
      sym_ready <= !(slow && ph_q[5:4] == 2'h3);
      // Keyed bits taken are counted in rx_bits and the last one is kept
      if (sym_valid && sym_ready && sym_on_air) begin
        rx_bits <= rx_bits + 32'h1;
        last_q <= sym_bit;
      end
    end
  end
endmodule

// ==== sim/rts_seq_chk.sv ====
// Property checker for the sequencer's register port and symbol stream.
// Assumes a bind to rts_sequencer; CTRL and FREQ writes are mirrored here.
`timescale 1ns/1ps
module rts_seq_chk
  import rts_pkg::*;
(
  input wire logic clk,  // Clock
  input wire logic resetn,  // Reset, low
  input wire logic [7:0] reg_addr,  // Address
  input wire logic [31:0] reg_wdata,  // Write data
  input wire logic reg_wr,  // Write strobe
  input wire logic reg_rd,  // Read strobe
  input wire logic [31:0] reg_rdata,  // Read data
  input wire logic sym_ready,  // Taken
  input wire logic sym_valid,  // Valid
  input wire logic sym_bit,  // Bit
  input wire logic sym_on_air,  // Keyed
  input wire logic [1:0] sym_slot,  // Slot
  input wire logic [4:0] sym_frame,  // Frame
  input wire logic [3:0] sym_chan_type  // Type
);
  logic [7:0] ctrl_q;
  logic [31:0] freq_q;
  wire bs = ctrl_q[RTS_CTRL_BS_BIT];
  wire rnd = ctrl_q[7:4] == RTS_CT_RAND;
  wire ts = sym_valid && !rnd;
  wire s0 = sym_slot == 2'h0;
  wire lead = s0 && sym_frame == 5'h12;
  // ==========================================================
  // Mirror of the mode and frequency registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= {RTS_TYPE_RST, 4'h0};
      freq_q <= RTS_FREQ_RST;
    end else if (reg_wr && reg_addr == RTS_REG_CTRL) begin
      ctrl_q <= reg_wdata[7:0];
    end else if (reg_wr && reg_addr == RTS_REG_FREQ) begin
      freq_q <= reg_wdata;
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  property p_freq; reg_rd && reg_addr == RTS_REG_FREQ |=> reg_rdata == freq_q; endproperty
  a_freq: assert property (p_freq)
    else $error("frequency readback wrong");
  property p_air; sym_on_air |-> sym_valid; endproperty
  a_air: assert property (p_air)
    else $error("keyed without a valid symbol");
  property p_hold;
    sym_valid && !sym_ready |=> sym_valid &&
      $stable({sym_bit, sym_on_air, sym_slot, sym_frame, sym_chan_type});
  endproperty
  a_hold: assert property (p_hold)
    else $error("symbol changed while stalled");
  property p_frame; sym_valid |-> sym_frame >= 5'h1 && sym_frame <= 5'h12; endproperty
  a_frame: assert property (p_frame)
    else $error("frame number out of range");
  property p_ms_ctrl; ts && !bs && lead |-> sym_chan_type == RTS_CT_SYNC_MS; endproperty
  a_ms_ctrl: assert property (p_ms_ctrl)
    else $error("mobile control slot not sync");
  property p_ms_fill; ts && !bs && !s0 |-> sym_chan_type == RTS_CT_FILL_MS; endproperty
  a_ms_fill: assert property (p_ms_fill)
    else $error("mobile filler type wrong");
  property p_sel; ts && s0 && !lead |-> sym_chan_type == ctrl_q[7:4]; endproperty
  a_sel: assert property (p_sel)
    else $error("selected type not sent");
  property p_bs_ctrl; ts && bs && lead |-> sym_chan_type == RTS_CT_SCHF_BS; endproperty
  a_bs_ctrl: assert property (p_bs_ctrl)
    else $error("base control slot type wrong");
  property p_bs_fill; ts && bs && !s0 |-> sym_chan_type == RTS_CT_FILL_BS; endproperty
  a_bs_fill: assert property (p_bs_fill)
    else $error("base filler type wrong");
  c_ms_lead: cover property (ts && !bs && lead);
  c_bs_lead: cover property (ts && bs && lead);
  c_rnd_key: cover property (rnd && $rose(sym_on_air));
  c_stall: cover property (sym_valid && !sym_ready);
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the radio test signal sequencer.
// Assumes the rtl package and sequencer plus the sim checker and model.
`timescale 1ns/1ps
module tb_top;
  import rts_pkg::*;
  logic clk, resetn, reg_wr, reg_rd, stall, sym_ready, sym_valid, sym_bit, sym_on_air, pa;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rx_bits;
  logic [1:0] sym_slot, ls;
  logic [4:0] sym_frame, lf;
  logic [3:0] sym_chan_type;
  int err_count, samples_checked, mode, run, gap, air, starts;
  bit first, done;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  rts_sequencer rts_sequencer_inst (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sym_ready, .sym_valid, .sym_bit, .sym_on_air, .sym_slot, .sym_frame,
    .sym_chan_type);
  rts_rx_model rts_rx_model_inst (.clk, .resetn, .slow(stall), .sym_valid, .sym_bit,
    .sym_on_air, .sym_ready, .rx_bits);
  // ==========================================================
  // Checking and bus tasks
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(name, exp, reg_rdata);
  endtask
  task automatic do_reset;
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    {first, done, pa, lf, ls, run, gap, air, starts} = '0;
    first = 1'b1;
  endtask
  // ==========================================================
  // Stream monitor: slot sequence, or random burst spacing
  always @(posedge clk) begin
    if (mode == 1 && sym_valid === 1'b1 && sym_ready === 1'b1) begin
      if ({sym_frame, sym_slot} !== {lf, ls}) begin
        if (!first) begin
          check("slot length", RTS_SLOT_SYMS, run);
          check("next slot", {(ls == 2'h3) ? ((lf == 5'h12) ? 5'h1 : lf + 5'h1) : lf,
            ls + 2'h1}, {sym_frame, sym_slot});
          if (lf == 5'h12) done = 1'b1;
        end
        first = 1'b0;
        lf = sym_frame;
        ls = sym_slot;
        run = 0;
      end
      run++;
    end
    if (mode == 2 && sym_valid === 1'b1 && sym_ready === 1'b1) begin
      gap++;
      if (sym_on_air) air++;
      if (sym_on_air && !pa) begin
        if (starts > 0) check("gap", 1, {31'h0, gap >= 800 && gap <= 25000});
        starts++;
        gap = 0;
      end
      if (!sym_on_air && pa) begin
        check("burst length", RTS_SYNC_SYMS, air);
        air = 0;
      end
      pa = sym_on_air;
      done = starts >= 2;
    end
  end
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rc(RTS_REG_CTRL, 32'h00000010, "ctrl reset");
    rc(RTS_REG_ECC, 32'h00000000, "ecc reset");
    rc(RTS_REG_FREQ, 32'h00000000, "freq reset");
    rc(RTS_REG_STATUS, 32'h01000100, "status reset");
    wr(RTS_REG_ECC, 32'hFFFFFFFF);
    rc(RTS_REG_ECC, 32'h3FFFFFFF, "ecc width");
    wr(RTS_REG_FREQ, 32'hA5C31E27);
    rc(RTS_REG_FREQ, 32'hA5C31E27, "freq");
    wr(RTS_REG_DUPLEX, 32'hFFFFFFFF);
    rc(RTS_REG_DUPLEX, 32'h000000FF, "duplex width");
    wr(8'h18, 32'hFFFFFFFF);
    rc(8'h18, 32'h00000000, "unmapped");
  endtask
  task automatic run_mode(input logic [31:0] ctrl, input int m, input bit slow, input int lim);
    do_reset;
    stall <= slow;
    mode = m;
    wr(RTS_REG_ECC, 32'h12345678);
    wr(RTS_REG_CTRL, ctrl);
    for (int i = 0; i < lim && !done; i++) @(posedge clk);
    mode = 0;
    check("run finished", 1, {31'h0, done});
    if (!done) wrap_up();
  endtask
  task automatic t_ms;
    run_mode(32'h00000041, 1, 1'b0, 20000);
    check("keyed bits seen", 1, {31'h0, rx_bits != 32'h0});
  endtask
  task automatic t_bs;
    run_mode(32'h00000093, 1, 1'b1, 26000);
  endtask
  task automatic t_rnd;
    run_mode(32'h000000D1, 2, 1'b0, 52000);
  endtask
  initial begin
    {resetn, reg_wr, reg_rd, stall, reg_addr, reg_wdata} = '0;
    mode = 0;
    do_reset;
    t_regs;
    t_ms;
    t_bs;
    t_rnd;
    wrap_up;
  end
endmodule
bind rts_sequencer rts_seq_chk rts_seq_chk_inst (.clk, .resetn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .sym_ready, .sym_valid, .sym_bit, .sym_on_air, .sym_slot,
  .sym_frame, .sym_chan_type);
